// File: src/pidsr_regs.vh
// Register offsets, field positions, reset values and timing counts of the PID speed regulator.
// Assumes a 32-bit APB slave at 125 MHz; every register takes one aligned word.
// Overview of operation
// - Cap output current at rated-current setting
// - Add torque boost to voltage during start-up
// - Add slip compensation above no-load current
// - PID mode: off, modulate, modulate plus shift
// - Setpoint from analog, stored target, serial
// - Feedback select positive or negative analog
// - Error sign follows feedback polarity
// - Integral time in ticks, zero disables
// - Derivative from present minus previous error
// - Clamp integral to max frequency times percent
// - Extension bits: offset, sign, gain ramp
// - Add signed offset when enabled
// - Ramp proportional gain over ramp time
// - Limit feedback to maximum percentage
// - Limit feedback to minimum percentage
// - Stored target value used for source three
`ifndef PIDSR_REGS_VH
`define PIDSR_REGS_VH

`define PIDSR_OFS_RATED_CUR   12'h000
`define PIDSR_OFS_NOLOAD_CUR  12'h004
`define PIDSR_OFS_TORQUE_CMP  12'h008
`define PIDSR_OFS_SLIP_CMP    12'h00C
`define PIDSR_OFS_PID_MODE    12'h010
`define PIDSR_OFS_SP_SRC      12'h014
`define PIDSR_OFS_FB_SEL      12'h018
`define PIDSR_OFS_KP          12'h01C
`define PIDSR_OFS_TI          12'h020
`define PIDSR_OFS_TD          12'h024
`define PIDSR_OFS_I_UPPER     12'h028
`define PIDSR_OFS_I_LIMIT     12'h02C
`define PIDSR_OFS_EXT_BITS    12'h030
`define PIDSR_OFS_OFFSET      12'h034
`define PIDSR_OFS_P_RAMP      12'h038
`define PIDSR_OFS_FB_MAX      12'h03C
`define PIDSR_OFS_FB_MIN      12'h040
`define PIDSR_OFS_TARGET      12'h044
`define PIDSR_OFS_SERIAL_SP   12'h048
`define PIDSR_OFS_MAX_FREQ    12'h04C
`define PIDSR_OFS_STATUS      12'h050
`define PIDSR_OFS_PID_OUT     12'h054

`define PIDSR_RST_RATED_CUR   16'h0055
`define PIDSR_RST_NOLOAD_CUR  16'h0032
`define PIDSR_RST_TORQUE_CMP  16'h0001
`define PIDSR_RST_SLIP_CMP    16'h0000
`define PIDSR_RST_PID_MODE    16'h0002
`define PIDSR_RST_SP_SRC      16'h0003
`define PIDSR_RST_FB_SEL      16'h0000
`define PIDSR_RST_KP          16'h0002
`define PIDSR_RST_TI          16'h0096
`define PIDSR_RST_TD          16'h0000
`define PIDSR_RST_I_UPPER     16'h0064
`define PIDSR_RST_I_LIMIT     16'h0000
`define PIDSR_RST_EXT_BITS    16'h0000
`define PIDSR_RST_OFFSET      16'h07D0
`define PIDSR_RST_P_RAMP      16'h03E8
`define PIDSR_RST_FB_MAX      16'h1F40
`define PIDSR_RST_FB_MIN      16'h07D0
`define PIDSR_RST_TARGET      16'h01F4
`define PIDSR_RST_MAX_FREQ    16'h9C40

`define PIDSR_EXT_OFS_EN      0
`define PIDSR_EXT_OFS_NEG     1
`define PIDSR_EXT_RAMP_EN     2

`define PIDSR_MODE_OFF        2'h0
`define PIDSR_MODE_MOD        2'h1
`define PIDSR_MODE_SHIFT      2'h2
`define PIDSR_SRC_ANALOG      3'h1
`define PIDSR_SRC_STORED      3'h3
`define PIDSR_SRC_SERIAL      3'h4
`define PIDSR_FB_NEG          2'h2

`define PIDSR_TICK_MS         20
`define PIDSR_CLK_KHZ         125000

`endif

// File: src/pidsr_ticker.v
// Tick generator for the PID regulator: one-cycle pulse every control period.
// Assumes clk at the rate given by the header; period is a parameter for simulation.
`timescale 1ns/1ps
`include "pidsr_regs.vh"

module pidsr_ticker #(
  parameter integer TICK_CYCLES = `PIDSR_TICK_MS * `PIDSR_CLK_KHZ
)
(
  // Clock and reset
  input  wire clk,
  input  wire arst_n,
  input  wire clk_en,
  // Tick out
  output reg  tick
);

  reg [31:0] count_reg;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_reg <= 32'h00000000;
      tick      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (count_reg >= TICK_CYCLES - 1)
      begin
        count_reg <= 32'h00000000;
        tick      <= 1'b1;
      end
      else
      begin
        count_reg <= count_reg + 32'h00000001;
        tick      <= 1'b0;
      end
    end
  end

endmodule // pidsr_ticker

// File: src/pidsr_regulator.v
// PID speed regulator with current limit, torque boost and slip compensation, behind an APB slave.
// Assumes analog input, current and master frequency are synchronous samples in clk domain.
// Scaling: feedback percent and volt values in hundredths, integral limit in whole percent, gains in tenths, frequency in hundredths of Hz.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "pidsr_regs.vh"

module pidsr_regulator #(
  parameter integer TICK_CYCLES = `PIDSR_TICK_MS * `PIDSR_CLK_KHZ
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Drive side
  input  wire [15:0] analog_voltage_input,
  input  wire [15:0] output_current,
  input  wire [15:0] master_freq,
  input  wire        starting,
  // Results
  output reg  [15:0] freq_cmd,
  output reg  [15:0] current_limit,
  output reg  [15:0] voltage_boost,
  output reg         current_capped
);

  reg  [15:0] rated_cur_reg, noload_cur_reg, torque_cmp_reg, slip_cmp_reg;
  reg  [1:0]  pid_mode_reg;
  reg  [2:0]  sp_src_reg;
  reg  [1:0]  fb_sel_reg;
  reg  [15:0] proportional_gain_setting, ti_reg, td_reg, i_upper_reg;
  reg         i_limit_reg;
  reg  [2:0]  pid_extension_bits;
  reg  [15:0] offset_reg, p_ramp_reg, fb_max_reg, fb_min_reg, stored_target_value;
  reg  [15:0] serial_sp_reg, max_freq_reg;
  reg  signed [31:0] integ_reg, prev_err_reg, pid_out_reg;
  reg  [15:0] ramp_cnt_reg;
  wire        tick;
  wire        apb_acc = psel && penable;
  wire        src_bad = (sp_src_reg != `PIDSR_SRC_ANALOG) && (sp_src_reg != `PIDSR_SRC_STORED)
                        && (sp_src_reg != `PIDSR_SRC_SERIAL);

  pidsr_ticker #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .tick   (tick)
  );

  // Setpoint and clamped feedback, in hundredths of a volt.
  reg  [15:0] setpoint, fb_lim, fb_pct_max, fb_pct_min;
  reg  signed [31:0] err, p_gain, p_term, i_next, i_clamp, d_term, pid_sum, offs;
  reg  signed [47:0] i_lim_w;
  always @*
  begin
    case (sp_src_reg)
      `PIDSR_SRC_ANALOG: setpoint = analog_voltage_input;
      `PIDSR_SRC_SERIAL: setpoint = serial_sp_reg;
      default:           setpoint = stored_target_value;
    endcase
    // Feedback limits are percent of 10.00 V full scale.
    fb_pct_max = fb_max_reg / 16'd10;
    fb_pct_min = fb_min_reg / 16'd10;
    if (analog_voltage_input > fb_pct_max)
      fb_lim = fb_pct_max;
    else if (analog_voltage_input < fb_pct_min)
      fb_lim = fb_pct_min;
    else
      fb_lim = analog_voltage_input;
    if (fb_sel_reg == `PIDSR_FB_NEG)
      err = $signed({16'h0000, setpoint}) - $signed({16'h0000, fb_lim});
    else
      err = $signed({16'h0000, fb_lim}) - $signed({16'h0000, setpoint});
    // Gain ramps linearly from zero to the set value when enabled.
    if (pid_extension_bits[`PIDSR_EXT_RAMP_EN] && p_ramp_reg != 16'h0000 && ramp_cnt_reg < p_ramp_reg)
      p_gain = $signed({16'h0000, proportional_gain_setting}) * $signed({16'h0000, ramp_cnt_reg})
               / $signed({16'h0000, p_ramp_reg});
    else
      p_gain = $signed({16'h0000, proportional_gain_setting});
    p_term = (err * p_gain) / 32'sd10;
    // Integral grows by error over Ti per tick, so it equals error after Ti ticks.
    if (ti_reg == 16'h0000)
      i_next = 32'sd0;
    else
      i_next = integ_reg + (err * 32'sd1000) / $signed({16'h0000, ti_reg});
    i_lim_w = ($signed({32'h00000000, max_freq_reg}) * $signed({32'h00000000, i_upper_reg}) * 48'sd10);
    i_clamp = i_next;
    if (i_next > $signed(i_lim_w[31:0]))
      i_clamp = i_lim_w[31:0];
    else if (i_next < -$signed(i_lim_w[31:0]))
      i_clamp = -$signed(i_lim_w[31:0]);
    if (i_limit_reg && i_clamp < 32'sd0)
      i_clamp = 32'sd0;
    d_term = ((err - prev_err_reg) * $signed({16'h0000, td_reg}));
    offs = pid_extension_bits[`PIDSR_EXT_OFS_NEG] ? -$signed({16'h0000, offset_reg})
                                                    : $signed({16'h0000, offset_reg});
    pid_sum = p_term + (i_clamp / 32'sd1000) + d_term;
    if (pid_extension_bits[`PIDSR_EXT_OFS_EN])
      pid_sum = pid_sum + offs;
  end

  // Final frequency command from mode, slip compensation and PID result.
  reg signed [31:0] f_work;
  always @*
  begin
    case (pid_mode_reg)
      `PIDSR_MODE_MOD:   f_work = pid_out_reg;
      `PIDSR_MODE_SHIFT: f_work = $signed({16'h0000, master_freq}) + pid_out_reg;
      default:           f_work = $signed({16'h0000, master_freq});
    endcase
    if (output_current > noload_cur_reg)
      f_work = f_work + $signed({16'h0000, slip_cmp_reg}) * 32'sd10;
    if (f_work < 32'sd0)
      f_work = 32'sd0;
    else if (f_work > $signed({16'h0000, max_freq_reg}))
      f_work = $signed({16'h0000, max_freq_reg});
  end

  // PID state and outputs.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      integ_reg      <= 32'sd0;
      prev_err_reg   <= 32'sd0;
      pid_out_reg    <= 32'sd0;
      ramp_cnt_reg   <= 16'h0000;
      freq_cmd       <= 16'h0000;
      current_limit  <= 16'h0000;
      voltage_boost  <= 16'h0000;
      current_capped <= 1'b0;
    end
    else if (clk_en)
    begin
      if (tick)
      begin
        integ_reg    <= i_clamp;
        prev_err_reg <= err;
        pid_out_reg  <= (pid_mode_reg == `PIDSR_MODE_OFF) ? 32'sd0 : pid_sum;
        if (!pid_extension_bits[`PIDSR_EXT_RAMP_EN])
          ramp_cnt_reg <= 16'h0000;
        else if (ramp_cnt_reg < p_ramp_reg)
          ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
      end
      freq_cmd       <= f_work[15:0];
      current_limit  <= rated_cur_reg;
      current_capped <= (output_current > rated_cur_reg);
      voltage_boost  <= starting ? torque_cmp_reg : 16'h0000;
    end
  end

  // APB slave: zero wait state, errors on unmapped offsets.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rated_cur_reg             <= `PIDSR_RST_RATED_CUR;
      noload_cur_reg            <= `PIDSR_RST_NOLOAD_CUR;
      torque_cmp_reg            <= `PIDSR_RST_TORQUE_CMP;
      slip_cmp_reg              <= `PIDSR_RST_SLIP_CMP;
      pid_mode_reg              <= `PIDSR_MODE_SHIFT;
      sp_src_reg                <= `PIDSR_SRC_STORED;
      fb_sel_reg                <= 2'h0;
      proportional_gain_setting <= `PIDSR_RST_KP;
      ti_reg                    <= `PIDSR_RST_TI;
      td_reg                    <= `PIDSR_RST_TD;
      i_upper_reg               <= `PIDSR_RST_I_UPPER;
      i_limit_reg               <= 1'b0;
      pid_extension_bits        <= 3'h0;
      offset_reg                <= `PIDSR_RST_OFFSET;
      p_ramp_reg                <= `PIDSR_RST_P_RAMP;
      fb_max_reg                <= `PIDSR_RST_FB_MAX;
      fb_min_reg                <= `PIDSR_RST_FB_MIN;
      stored_target_value       <= `PIDSR_RST_TARGET;
      serial_sp_reg             <= 16'h0000;
      max_freq_reg              <= `PIDSR_RST_MAX_FREQ;
      prdata                    <= 32'h00000000;
      pready                    <= 1'b0;
      pslverr                   <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        prdata <= 32'h00000000;
        case (paddr)
          `PIDSR_OFS_RATED_CUR:  prdata <= {16'h0000, rated_cur_reg};
          `PIDSR_OFS_NOLOAD_CUR: prdata <= {16'h0000, noload_cur_reg};
          `PIDSR_OFS_TORQUE_CMP: prdata <= {16'h0000, torque_cmp_reg};
          `PIDSR_OFS_SLIP_CMP:   prdata <= {16'h0000, slip_cmp_reg};
          `PIDSR_OFS_PID_MODE:   prdata <= {30'h00000000, pid_mode_reg};
          `PIDSR_OFS_SP_SRC:     prdata <= {29'h00000000, sp_src_reg};
          `PIDSR_OFS_FB_SEL:     prdata <= {30'h00000000, fb_sel_reg};
          `PIDSR_OFS_KP:         prdata <= {16'h0000, proportional_gain_setting};
          `PIDSR_OFS_TI:         prdata <= {16'h0000, ti_reg};
          `PIDSR_OFS_TD:         prdata <= {16'h0000, td_reg};
          `PIDSR_OFS_I_UPPER:    prdata <= {16'h0000, i_upper_reg};
          `PIDSR_OFS_I_LIMIT:    prdata <= {31'h00000000, i_limit_reg};
          `PIDSR_OFS_EXT_BITS:   prdata <= {29'h00000000, pid_extension_bits};
          `PIDSR_OFS_OFFSET:     prdata <= {16'h0000, offset_reg};
          `PIDSR_OFS_P_RAMP:     prdata <= {16'h0000, p_ramp_reg};
          `PIDSR_OFS_FB_MAX:     prdata <= {16'h0000, fb_max_reg};
          `PIDSR_OFS_FB_MIN:     prdata <= {16'h0000, fb_min_reg};
          `PIDSR_OFS_TARGET:     prdata <= {16'h0000, stored_target_value};
          `PIDSR_OFS_SERIAL_SP:  prdata <= {16'h0000, serial_sp_reg};
          `PIDSR_OFS_MAX_FREQ:   prdata <= {16'h0000, max_freq_reg};
          `PIDSR_OFS_STATUS:     prdata <= {29'h00000000, src_bad, current_capped, 1'b1};
          `PIDSR_OFS_PID_OUT:    prdata <= pid_out_reg;
          default:               pslverr <= 1'b1;
        endcase
        if (paddr > `PIDSR_OFS_PID_OUT || paddr[1:0] != 2'b00)
          pslverr <= 1'b1;
      end
      // Writes land at the access edge; out-of-range numeric values are clipped to the legal span, mode 3 and odd feedback codes are ignored, any source code is stored.
      if (apb_acc && pwrite && pready && !pslverr)
      begin
        case (paddr)
          `PIDSR_OFS_RATED_CUR:  rated_cur_reg  <= (pwdata[15:0] < 16'd30) ? 16'd30 :
                                                   (pwdata[15:0] > 16'd120) ? 16'd120 : pwdata[15:0];
          `PIDSR_OFS_NOLOAD_CUR: noload_cur_reg <= (pwdata[15:0] > 16'd90) ? 16'd90 : pwdata[15:0];
          `PIDSR_OFS_TORQUE_CMP: torque_cmp_reg <= (pwdata[15:0] > 16'd10) ? 16'd10 : pwdata[15:0];
          `PIDSR_OFS_SLIP_CMP:   slip_cmp_reg   <= (pwdata[15:0] > 16'd100) ? 16'd100 : pwdata[15:0];
          `PIDSR_OFS_PID_MODE:   pid_mode_reg   <= (pwdata[1:0] == 2'h3) ? pid_mode_reg : pwdata[1:0];
          `PIDSR_OFS_SP_SRC:     sp_src_reg     <= pwdata[2:0];
          `PIDSR_OFS_FB_SEL:     fb_sel_reg     <= (pwdata[0]) ? fb_sel_reg : pwdata[1:0];
          `PIDSR_OFS_KP:         proportional_gain_setting <= (pwdata[15:0] > 16'd100) ? 16'd100 : pwdata[15:0];
          `PIDSR_OFS_TI:         ti_reg         <= (pwdata[15:0] > 16'd1000) ? 16'd1000 : pwdata[15:0];
          `PIDSR_OFS_TD:         td_reg         <= (pwdata[15:0] > 16'd20) ? 16'd20 : pwdata[15:0];
          `PIDSR_OFS_I_UPPER:    i_upper_reg    <= (pwdata[15:0] > 16'd100) ? 16'd100 : pwdata[15:0];
          `PIDSR_OFS_I_LIMIT:    i_limit_reg    <= pwdata[0];
          `PIDSR_OFS_EXT_BITS:   pid_extension_bits <= pwdata[2:0];
          `PIDSR_OFS_OFFSET:     offset_reg     <= (pwdata[15:0] > 16'd40000) ? 16'd40000 : pwdata[15:0];
          `PIDSR_OFS_P_RAMP:     p_ramp_reg     <= (pwdata[15:0] > 16'd1000) ? 16'd1000 : pwdata[15:0];
          `PIDSR_OFS_FB_MAX:     fb_max_reg     <= (pwdata[15:0] > 16'd10000) ? 16'd10000 : pwdata[15:0];
          `PIDSR_OFS_FB_MIN:     fb_min_reg     <= (pwdata[15:0] > 16'd10000) ? 16'd10000 : pwdata[15:0];
          `PIDSR_OFS_TARGET:     stored_target_value <= (pwdata[15:0] > 16'd1000) ? 16'd1000 : pwdata[15:0];
          `PIDSR_OFS_SERIAL_SP:  serial_sp_reg  <= pwdata[15:0];
          `PIDSR_OFS_MAX_FREQ:   max_freq_reg   <= pwdata[15:0];
          default:               ;
        endcase
      end
    end
  end

endmodule // pidsr_regulator

// File: tb/pidsr_checker.sv
// Concurrent checks on the ports of the PID speed regulator, bound to every instance.
// Assumes one clock domain with an active-low asynchronous reset and an APB master that keeps the protocol.
`timescale 1ns/1ps

module pidsr_checker #(
  parameter integer TICK_CYCLES = 50
)
(
  // Clock and reset
  input logic        clk,
  input logic        arst_n,
  input logic        clk_en,
  // APB
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic        pready,
  input logic        pslverr,
  // Drive side and results
  input logic [15:0] output_current,
  input logic        starting,
  input logic [15:0] current_limit,
  input logic [15:0] voltage_boost,
  input logic        current_capped
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_apb_answer: assert property (psel && !penable && clk_en |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready && clk_en |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without a setup cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_unaligned_err: assert property (psel && !penable && clk_en && (paddr[1:0] != 2'h0) |=> pslverr)
    else $error("unaligned access not refused");
  // The guard skips the cycle after a rated-current change, when limit and flag may differ by one update.
  chk_cap_flag: assert property ($past(arst_n) && $stable(current_limit)
    |-> current_capped == ($past(output_current) > $past(current_limit)))
    else $error("current_capped does not follow current and limit");
  chk_limit_range: assert property ($past(arst_n) |-> current_limit >= 16'h001E && current_limit <= 16'h0078)
    else $error("current_limit outside its range");
  chk_boost_idle: assert property ($past(arst_n) && !$past(starting) |-> voltage_boost == 16'h0000)
    else $error("voltage_boost outside start-up");
  chk_boost_range: assert property (voltage_boost <= 16'h000A)
    else $error("voltage_boost above its range");

  cov_err: cover property (pready && pslverr);
  cov_capped: cover property ($rose(current_capped));
  cov_boost: cover property (voltage_boost != 16'h0000);
endmodule // pidsr_checker

bind pidsr_regulator pidsr_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.clk(clk), .arst_n(arst_n),
  .clk_en(clk_en), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .output_current(output_current), .starting(starting), .current_limit(current_limit),
  .voltage_boost(voltage_boost), .current_capped(current_capped));

// File: tb/pidsr_drive_model.sv
// Behavioural model of the feedback sensor and the frequency command source of the drive.
// Assumes the bench sets wanted values at a rising edge; the model presents them one cycle later.
`timescale 1ns/1ps

module pidsr_drive_model (
  // Clock and reset
  input  logic        clk,
  input  logic        arst_n,
  // Wanted values
  input  logic [15:0] want_analog,
  input  logic [15:0] want_cur,
  input  logic [15:0] want_master,
  input  logic        want_start,
  // Drive side
  output logic [15:0] analog_voltage_input,
  output logic [15:0] output_current,
  output logic [15:0] master_freq,
  output logic        starting
);
  // The sensor saturates at 10 V, so the regulator never sees more than full scale.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      analog_voltage_input <= 16'h0000;
      output_current       <= 16'h0000;
      master_freq          <= 16'h0000;
      starting             <= 1'b0;
    end
    else
    begin
      analog_voltage_input <= (want_analog > 16'h03E8) ? 16'h03E8 : want_analog;
      output_current       <= want_cur;
      master_freq          <= want_master;
      starting             <= want_start;
    end
  end
endmodule // pidsr_drive_model

// File: tb/pidsr_regulator_test.sv
// Self-checking bench of the PID speed regulator: APB master, drive-side model and result queue.
// Assumes the regulator answers every setup in the next cycle and ticks every TICK cycles.
`timescale 1ns/1ps
`include "pidsr_regs.vh"
`define PIDSR_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module pidsr_regulator_test;
  localparam integer TICK = 50;
  typedef struct { int sel; logic [31:0] exp; } pidsr_note_t;
  logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, starting, current_capped, want_start = 1'b0;
  logic [15:0] analog_voltage_input, output_current, master_freq, freq_cmd, current_limit, voltage_boost;
  logic [15:0] want_analog = 16'h0, want_cur = 16'h0, want_master = 16'h0, ef;
  logic [15:0] dflt [0:19];
  logic [1:0]  cfb [0:5];
  logic [15:0] can [0:5];
  logic [15:0] cext [0:5];
  logic [15:0] cexp [0:5];
  pidsr_note_t q[$], n;
  int n_fail = 0, n_checks = 0;

  initial forever #4 clk = ~clk;
  pidsr_drive_model far (.clk(clk), .arst_n(arst_n), .want_analog(want_analog), .want_cur(want_cur),
    .want_master(want_master), .want_start(want_start), .analog_voltage_input(analog_voltage_input),
    .output_current(output_current), .master_freq(master_freq), .starting(starting));
  pidsr_regulator #(.TICK_CYCLES(TICK)) uut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analog_voltage_input(analog_voltage_input), .output_current(output_current),
    .master_freq(master_freq), .starting(starting), .freq_cmd(freq_cmd), .current_limit(current_limit),
    .voltage_boost(voltage_boost), .current_capped(current_capped));

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic err);
    int cnt;
    cnt = 0;
    q.push_back('{1, {31'h0, err}});
    if (!wr && !err) q.push_back('{0, e});
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && cnt < 50)
    begin
      @(posedge clk);
      cnt++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d, 32'h0, 1'b0); endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0, e, 1'b0); endtask
  task automatic idle(); psel <= 1'b0; penable <= 1'b0; @(posedge clk); endtask
  task automatic look(input int s, input logic [31:0] e); q.push_back('{s, e}); @(negedge clk); @(posedge clk);
  endtask
  task automatic wait_ticks(input int k); repeat (k * TICK + 4) @(posedge clk); endtask

  // Bus results are matched at the answering edge, drive-side results at the falling edge.
  always @(posedge clk)
    if (psel && penable && pready === 1'b1)
    begin
      if (q.size() == 0) n_fail++;
      else
      begin
        n = q.pop_front();
        `PIDSR_CHK("pslverr", n.exp[0], pslverr)
        if (!pwrite && n.exp[0] == 1'b0 && q.size() > 0)
        begin
          n = q.pop_front();
          `PIDSR_CHK("prdata", n.exp, prdata)
        end
      end
    end
  always @(negedge clk)
    while (q.size() > 0 && q[0].sel >= 2)
    begin
      n = q.pop_front();
      case (n.sel)
        2: `PIDSR_CHK("freq_cmd", n.exp[15:0], freq_cmd)
        3: `PIDSR_CHK("current_limit", n.exp[15:0], current_limit)
        4: `PIDSR_CHK("voltage_boost", n.exp[15:0], voltage_boost)
        default: `PIDSR_CHK("current_capped", n.exp[0], current_capped)
      endcase
    end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #(8 * 20000);
    n_fail++;
    finish_test();
  end

  initial
  begin
    dflt = '{`PIDSR_RST_RATED_CUR, `PIDSR_RST_NOLOAD_CUR, `PIDSR_RST_TORQUE_CMP, `PIDSR_RST_SLIP_CMP,
      `PIDSR_RST_PID_MODE, `PIDSR_RST_SP_SRC, `PIDSR_RST_FB_SEL, `PIDSR_RST_KP, `PIDSR_RST_TI, `PIDSR_RST_TD,
      `PIDSR_RST_I_UPPER, `PIDSR_RST_I_LIMIT, `PIDSR_RST_EXT_BITS, `PIDSR_RST_OFFSET, `PIDSR_RST_P_RAMP,
      `PIDSR_RST_FB_MAX, `PIDSR_RST_FB_MIN, `PIDSR_RST_TARGET, 16'h0000, `PIDSR_RST_MAX_FREQ};
    // Target 5.00 V, gain 1.0: error in hundredths of a volt, offset 20.00 when enabled.
    cfb = '{2'h2, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2};
    can = '{16'h012C, 16'h012C, 16'h0384, 16'h0064, 16'h012C, 16'h012C};
    cext = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h3};
    cexp = '{16'h00C8, 16'hFF38, 16'hFED4, 16'h012C, 16'h0898, 16'hF8F8};
    void'($urandom(32'h8E22));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 20; i++)
      if (i != 18) rd(12'(i * 4), {16'h0, dflt[i]});
    apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h006, 32'h0, 32'h0, 1'b1);
    wr(`PIDSR_OFS_PID_MODE, 32'h3); rd(`PIDSR_OFS_PID_MODE, 32'h2);
    for (int m = 0; m < 3; m++) begin wr(`PIDSR_OFS_PID_MODE, m); rd(`PIDSR_OFS_PID_MODE, m); end
    wr(`PIDSR_OFS_FB_SEL, 32'h1); rd(`PIDSR_OFS_FB_SEL, 32'h0);
    wr(`PIDSR_OFS_FB_SEL, 32'h2); rd(`PIDSR_OFS_FB_SEL, 32'h2);
    // Source code 2 is no defined source and falls back to the stored target; the status word reports a bad source while it is set.
    wr(`PIDSR_OFS_SP_SRC, 32'h2); rd(`PIDSR_OFS_SP_SRC, 32'h2);
    rd(`PIDSR_OFS_STATUS, 32'h5);
    wr(`PIDSR_OFS_SP_SRC, 32'h4); rd(`PIDSR_OFS_SP_SRC, 32'h4);
    wr(`PIDSR_OFS_RATED_CUR, 32'hC8); rd(`PIDSR_OFS_RATED_CUR, 32'h78);
    wr(`PIDSR_OFS_RATED_CUR, 32'h64);
    wr(`PIDSR_OFS_TORQUE_CMP, 32'h7);
    idle();
    look(3, 32'h64);
    for (int k = 0; k < 4; k++)
    begin
      want_cur <= 16'($urandom_range(200));
      repeat (3) @(posedge clk);
      look(5, {31'h0, want_cur > 16'h0064});
    end
    want_start <= 1'b1;
    repeat (3) @(posedge clk);
    look(4, 32'h7);
    want_start <= 1'b0;
    repeat (3) @(posedge clk);
    look(4, 32'h0);
    wr(`PIDSR_OFS_PID_MODE, 32'h0);
    wr(`PIDSR_OFS_SLIP_CMP, 32'h19);
    idle();
    for (int k = 0; k < 4; k++)
    begin
      want_master <= 16'($urandom_range(30000));
      want_cur <= (k % 2 == 0) ? 16'h003C : 16'h0028;
      wait_ticks(2);
      ef = want_master + ((want_cur > 16'h0032) ? 16'h00FA : 16'h0000);
      look(2, {16'h0, ef});
    end
    wr(`PIDSR_OFS_TI, 32'h0); wr(`PIDSR_OFS_KP, 32'hA); wr(`PIDSR_OFS_SP_SRC, 32'h3);
    wr(`PIDSR_OFS_PID_MODE, 32'h1);
    for (int c = 0; c < 6; c++)
    begin
      wr(`PIDSR_OFS_FB_SEL, {30'h0, cfb[c]});
      wr(`PIDSR_OFS_EXT_BITS, {16'h0, cext[c]});
      idle();
      want_analog <= can[c];
      wait_ticks(3);
      // The PID result reads back as a signed 32-bit word, so negative cases carry ones above bit 15.
      rd(`PIDSR_OFS_PID_OUT, {{16{cexp[c][15]}}, cexp[c]});
      idle();
    end
    finish_test();
  end
endmodule // pidsr_regulator_test
